/* swd_params.svh */
/*
  Constants for the second-stage walk attribute decoder: entry field
  positions, register offsets, control field positions and reset values.
  Assumes nothing. Include it by its bare name.
*/
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH

// ==========================================================================
// entry field positions, relative to entry bit 160 (word 5 of the entry)
`define SWD_ENTRY_BASE      160
`define SWD_IR_LSB          8
`define SWD_OR_LSB          10
`define SWD_SH_LSB          12
`define SWD_TG_LSB          14
`define SWD_PS_LSB          16
`define SWD_FMT_BIT         19
`define SWD_CFG_S2_BIT      1

// ==========================================================================
// register byte offsets
`define SWD_CTRL_OFS        12'h000
`define SWD_STATUS_OFS      12'h004
`define SWD_FAULTCNT_OFS    12'h008

// ==========================================================================
// control register fields and reset value
`define SWD_CTRL_PRESENT    0
`define SWD_CTRL_LATER_REV  1
`define SWD_CTRL_FLAG_UPD   2
`define SWD_CTRL_GSUP_LSB   4
`define SWD_CTRL_CAP_LSB    8
`define SWD_CTRL_W          11
`define SWD_CTRL_RST        11'h571

// ==========================================================================
// encodings
`define SWD_PS_40           3'h2
`define SWD_PS_48           3'h5
`define SWD_PS_52           3'h6
`define SWD_PS_RSVD         3'h7
`define SWD_TG_RSVD         2'h3
`define SWD_SH_RSVD         2'h1
`define SWD_SH_NON          2'h0
`define SWD_SH_OUTER        2'h2
`define SWD_CACHE_NC        2'h0
`define SWD_ADDR_W          52
`define SWD_HI_LSB          48

`endif

/* swd_pkg.sv */
/*
  Types shared by the walk attribute decoder.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package swd_pkg;
  // granule encodings as stored in the entry
  typedef enum logic [1:0] {
    SWD_GRAN_4K   = 2'h0,
    SWD_GRAN_64K  = 2'h1,
    SWD_GRAN_16K  = 2'h2,
    SWD_GRAN_RSVD = 2'h3
  } swd_gran_t;
endpackage
`default_nettype wire

/* swd_decoder.sv */
/*
  Second-stage walk attribute decoder. Decodes cacheability, shareability,
  granule and output size fields of a stream table entry, flags illegal
  entries, checks walk output addresses against the effective size, and
  exposes control and status over an APB slave.
  Assumes the walker drives the entry fields synchronously to pclk and
  supplies its own input-size/start-level consistency verdict.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swd_params.svh"

// Behaviour
// - flag updates happen only when inner and outer walk attrs are write-back.
// - with no second stage present, all walk fields read as zero.
// - bits 171:170 are outer walk cacheability, encoded like inner.
// - bits 173:172 are walk shareability: 00 non, 10 outer, 11 inner.
// - shareability 01 behaves as 00, non-shareable.
// - inner and outer non-cacheable forces outer shareable walks.
// - bits 175:174 select granule: 00 4KB, 01 64KB, 10 16KB, 11 reserved.
// - granule field ignored while second-stage translation is off.
// - 32-bit table format forces a 4KB granule.
// - 64-bit format with reserved or unsupported granule makes entry illegal.
// - inconsistent region size or start level makes entry illegal.
// - bits 178:176 set output size: 32,36,40,42,44,48,52 bits.
// - earlier revision treats output encodings 110 and 111 as 101.
// - later revision treats output encoding 111 as 110.
// - inner cacheability: 00 NC, 01 WB RA WA, 10 WT RA, 11 WB RA.
// - bit 179 selects table format: 0 32-bit, 1 64-bit.
// - fault when output address bits 47 (51 with a 64KB granule) down to effective size are nonzero.
// - config bit 1 enables second stage; legality checks apply only then.
module swd_decoder (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // entry fields from the walker
  input  wire logic        entry_valid,
  input  wire logic [2:0]  entry_config_field,
  input  wire logic [31:0] entry_word,
  input  wire logic        size_level_consistent,
  // output address check
  input  wire logic        addr_check_valid,
  input  wire logic [51:0] walk_out_addr,
  // decoded results to the walker
  output logic [1:0]       eff_inner_cache,
  output logic [1:0]       eff_outer_cache,
  output logic [1:0]       eff_share,
  output logic [1:0]       eff_granule,
  output logic [2:0]       eff_out_size_enc,
  output logic [5:0]       eff_out_size_bits,
  output logic             walk_64bit_format,
  output logic             hw_table_flag_update,
  output logic             entry_illegal,
  output logic             addr_size_fault
);

  // ==========================================================================
  // registers
  logic [`SWD_CTRL_W-1:0] ctrl_reg;
  logic [15:0]            status_reg;
  logic [15:0]            faultcnt_reg;
  logic [15:0]            faultcnt_next;

  // ==========================================================================
  // control fields
  wire logic       present      = ctrl_reg[`SWD_CTRL_PRESENT];
  wire logic       later_rev    = ctrl_reg[`SWD_CTRL_LATER_REV];
  wire logic       flag_upd_en  = ctrl_reg[`SWD_CTRL_FLAG_UPD];
  wire logic [2:0] gran_support = ctrl_reg[`SWD_CTRL_GSUP_LSB +: 3]; // 4K, 16K, 64K
  wire logic [2:0] size_cap     = ctrl_reg[`SWD_CTRL_CAP_LSB +: 3];

  // ==========================================================================
  // field extraction; absent second stage reads everything as zero
  wire logic [31:0] fields     = present ? entry_word : 32'h0000_0000;
  wire logic        s2_enabled = present & entry_config_field[`SWD_CFG_S2_BIT];
  wire logic [1:0]  raw_ir     = fields[`SWD_IR_LSB +: 2];
  wire logic [1:0]  raw_or     = fields[`SWD_OR_LSB +: 2];
  wire logic [1:0]  raw_sh     = fields[`SWD_SH_LSB +: 2];
  wire logic [1:0]  raw_tg     = fields[`SWD_TG_LSB +: 2];
  wire logic [2:0]  raw_ps     = fields[`SWD_PS_LSB +: 3];
  wire logic        fmt64      = fields[`SWD_FMT_BIT];

  // ==========================================================================
  // shareability: reserved folds to non, non-cacheable forces outer
  wire logic        both_nc  = (raw_ir == `SWD_CACHE_NC) && (raw_or == `SWD_CACHE_NC);
  wire logic [1:0]  sh_fold  = (raw_sh == `SWD_SH_RSVD) ? `SWD_SH_NON : raw_sh;
  assign eff_share       = both_nc ? `SWD_SH_OUTER : sh_fold;
  // all decode is combinational so the walker sees results in the entry's own cycle
  assign eff_inner_cache = raw_ir;
  assign eff_outer_cache = raw_or;

  // flag updates only when both walk attrs are write-back (01 or 11);
  // the non-cacheable and write-through cases skip them since the
  // atomic update may need the descriptor already cached
  assign hw_table_flag_update = flag_upd_en & raw_ir[0] & raw_or[0];

  // ==========================================================================
  // granule: ignored when stage off, forced 4K for 32-bit tables
  wire logic gran_rsvd = (raw_tg == `SWD_TG_RSVD);
  wire logic gran_sup  = (raw_tg == swd_pkg::SWD_GRAN_4K)  ? gran_support[0] :
                         (raw_tg == swd_pkg::SWD_GRAN_16K) ? gran_support[1] :
                         (raw_tg == swd_pkg::SWD_GRAN_64K) ? gran_support[2] : 1'b0;
  wire logic use_tg    = s2_enabled & fmt64 & ~gran_rsvd;
  assign eff_granule   = use_tg ? raw_tg : swd_pkg::SWD_GRAN_4K;
  assign walk_64bit_format = fmt64;

  // ==========================================================================
  // legality, only while second-stage translation is on
  wire logic gran_bad = fmt64 & (gran_rsvd | ~gran_sup);
  assign entry_illegal = s2_enabled & (gran_bad | ~size_level_consistent);

  // ==========================================================================
  // output size: reserved substitution per revision, then cap
  wire logic [2:0] ps_top  = later_rev ? `SWD_PS_52 : `SWD_PS_48;
  wire logic [2:0] ps_sub  = (raw_ps == `SWD_PS_RSVD) ? ps_top :
                             (raw_ps == `SWD_PS_52 && !later_rev) ? `SWD_PS_48 : raw_ps;
  wire logic [2:0] ps_cap  = (size_cap > ps_top) ? ps_top : size_cap;
  wire logic [2:0] ps_min  = (ps_sub > ps_cap) ? ps_cap : ps_sub;
  assign eff_out_size_enc  = fmt64 ? ps_min : `SWD_PS_40;

  // encoding to bit count
  function automatic logic [5:0] swd_size_bits(input logic [2:0] enc);
    logic [5:0] bits;
    bits = 6'h20;
    case (enc)
      3'h0:    bits = 6'h20;
      3'h1:    bits = 6'h24;
      3'h2:    bits = 6'h28;
      3'h3:    bits = 6'h2A;
      3'h4:    bits = 6'h2C;
      3'h5:    bits = 6'h30;
      default: bits = 6'h34;
    endcase
    return bits;
  endfunction

  assign eff_out_size_bits = swd_size_bits(eff_out_size_enc);

  // ==========================================================================
  // address size fault; bits 51:48 count only with a 64K granule
  wire logic [51:0] low_mask  = (52'h1 << eff_out_size_bits) - 52'h1;
  wire logic [51:0] hi_mask   = (eff_granule == swd_pkg::SWD_GRAN_64K) ? 52'hF_FFFF_FFFF_FFFF
                                                                       : 52'h0_FFFF_FFFF_FFFF;
  wire logic [51:0] over_bits = walk_out_addr & ~low_mask & hi_mask;
  assign addr_size_fault = addr_check_valid & s2_enabled & (|over_bits);

  // ==========================================================================
  // apb decode; zero wait states, unmapped offsets answer with an error
  wire logic access     = psel & penable;
  wire logic hit_ctrl   = (paddr == `SWD_CTRL_OFS);
  wire logic hit_status = (paddr == `SWD_STATUS_OFS);
  wire logic hit_fcnt   = (paddr == `SWD_FAULTCNT_OFS);
  wire logic mapped     = hit_ctrl | hit_status | hit_fcnt;
  wire logic wr_ctrl    = access & pwrite & hit_ctrl;
  wire logic wr_fcnt    = access & pwrite & hit_fcnt;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = ~access   ? 32'h0000_0000 :
                   hit_ctrl  ? {21'h0, ctrl_reg} :
                   hit_status ? {16'h0, status_reg} :
                   hit_fcnt  ? {16'h0, faultcnt_reg} : 32'h0000_0000;

  // fault counter: a fault in the clearing cycle still counts
  wire logic fault_sat = &faultcnt_reg;
  assign faultcnt_next = wr_fcnt ? {15'h0, addr_size_fault} :
                         (addr_size_fault & ~fault_sat) ? faultcnt_reg + 16'h1 : faultcnt_reg;

  // ==========================================================================
  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SWD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[`SWD_CTRL_W-1:0];
    end
  end

  // snapshot of the last decoded entry, for software to inspect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 16'h0000;
    end else if (entry_valid) begin
      status_reg <= {1'b0, hw_table_flag_update, walk_64bit_format, s2_enabled,
                     entry_illegal, eff_out_size_enc, eff_granule, eff_share,
                     eff_outer_cache, eff_inner_cache};
    end
  end

  // address size fault counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faultcnt_reg <= 16'h0000;
    end else begin
      faultcnt_reg <= faultcnt_next;
    end
  end

endmodule
`default_nettype wire

/* swd_entry_model.sv */
/*
  Software side model: lays out a stream table entry word from chosen fields.
  Assumes the bench changes the fields just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
// ====
// entry layout
module swd_entry_model (
  // fields: fmt, size, granule, share, outer, inner
  input  wire logic [11:0] fields,
  input  wire logic [2:0]  cfg,
  // entry as the decoder sees it
  output logic      [31:0] entry_word,
  output logic      [2:0]  entry_config_field
);
  // other bits left zero; reserved encodings pass through for the decoder to substitute
  assign entry_word         = {12'h000, fields, 8'h00};
  assign entry_config_field = cfg;
endmodule
`default_nettype wire

/* swd_decoder_sva.sv */
/*
  Checker for the walk attribute decoder, bound to its ports.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
// ====
// decode checks
module swd_decoder_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // entry and address inputs
  input wire logic [2:0]  entry_config_field,
  input wire logic [31:0] entry_word,
  input wire logic        size_level_consistent,
  input wire logic        addr_check_valid,
  input wire logic [51:0] walk_out_addr,
  // decoded outputs
  input wire logic [1:0]  eff_inner_cache,
  input wire logic [1:0]  eff_outer_cache,
  input wire logic [1:0]  eff_share,
  input wire logic [1:0]  eff_granule,
  input wire logic [2:0]  eff_out_size_enc,
  input wire logic [5:0]  eff_out_size_bits,
  input wire logic        walk_64bit_format,
  input wire logic        hw_table_flag_update,
  input wire logic        entry_illegal,
  input wire logic        addr_size_fault
);
  localparam logic [5:0] sz_tab [7] = '{6'h20, 6'h24, 6'h28, 6'h2A, 6'h2C, 6'h30, 6'h34};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // nonzero inner cache proves the stage is present
  share_fold_a: assert property (eff_outer_cache != 2'h0 && entry_word[13:12] == 2'h1 |-> eff_share == 2'h0)
    else $error("reserved share not folded");
  share_nc_a: assert property (eff_inner_cache == 2'h0 && eff_outer_cache == 2'h0 |-> eff_share == 2'h2)
    else $error("non-cacheable walk not outer shareable");
  share_map_a: assert property (eff_outer_cache != 2'h0 && entry_word[13] |-> eff_share == entry_word[13:12])
    else $error("share field not passed");
  outer_src_a: assert property (eff_inner_cache != 2'h0 |-> eff_outer_cache == entry_word[11:10])
    else $error("outer cache field wrong");
  gran_off_a: assert property (!entry_config_field[1] |-> eff_granule == 2'h0 && !entry_illegal)
    else $error("granule used with stage off");
  gran_fmt32_a: assert property (entry_config_field[1] && !walk_64bit_format |-> eff_granule == 2'h0)
    else $error("32-bit format granule not 4KB");
  gran_rsvd_a: assert property (entry_config_field[1] && walk_64bit_format && entry_word[15:14] == 2'h3 |-> entry_illegal)
    else $error("reserved granule not illegal");
  size_lvl_a: assert property (entry_config_field[1] && walk_64bit_format && !size_level_consistent |-> entry_illegal)
    else $error("inconsistent size not illegal");
  size_map_a: assert property (eff_out_size_enc != 3'h7 && eff_out_size_bits == sz_tab[eff_out_size_enc])
    else $error("output size mapping wrong");
  flag_wb_a: assert property (hw_table_flag_update |-> eff_inner_cache[0] && eff_outer_cache[0])
    else $error("flag update outside write-back");
  fault_hit_a: assert property (addr_size_fault == (addr_check_valid && entry_config_field[1]
    && ((walk_out_addr & ((eff_granule == 2'h1) ? 52'hF_FFFF_FFFF_FFFF : 52'h0_FFFF_FFFF_FFFF))
    >> eff_out_size_bits) != 52'h0))
    else $error("address size fault wrong");
endmodule
bind swd_decoder swd_decoder_sva i_sva (.pclk, .presetn, .entry_config_field, .entry_word, .size_level_consistent,
  .addr_check_valid, .walk_out_addr, .eff_inner_cache, .eff_outer_cache, .eff_share, .eff_granule, .eff_out_size_enc,
  .eff_out_size_bits, .walk_64bit_format, .hw_table_flag_update, .entry_illegal, .addr_size_fault);
`default_nettype wire

/* testbench.sv */
/*
  Bench for the walk attribute decoder: registers over apb, a table of entries,
  then revision, granule support, fault count and absent stage by hand.
  Assumes the decoder, checker and entry model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module testbench;
  typedef struct packed {
    logic [2:0] cfg; logic [1:0] ir, orr, sh, tg; logic [2:0] ps; logic fmt, cons;
    logic [1:0] esh, eg; logic [2:0] eps; logic ill;
  } swd_row_t;
  // later revision, cap 52, flag update on; write-back walks where flags update
  localparam swd_row_t rows [7] = '{'{2,1,1,0,0,0,1,1,0,0,0,0}, '{2,1,3,1,1,6,1,1,0,1,6,0},
    '{2,0,0,3,2,7,1,1,2,2,6,0}, '{2,2,1,2,3,3,1,1,2,0,3,1}, '{2,1,1,3,3,4,0,1,3,0,2,0},
    '{0,3,3,2,3,5,1,0,2,0,5,0}, '{2,3,1,0,2,1,1,0,0,2,1,1}};
  localparam logic [5:0] sz [7] = '{6'h20, 6'h24, 6'h28, 6'h2A, 6'h2C, 6'h30, 6'h34};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, entry_valid, addr_check_valid;
  logic        walk_64bit_format, hw_table_flag_update, entry_illegal, addr_size_fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, entry_word, q;
  logic [2:0]  entry_config_field, eff_out_size_enc;
  logic [1:0]  eff_inner_cache, eff_outer_cache, eff_share, eff_granule;
  logic [5:0]  eff_out_size_bits;
  logic [51:0] walk_out_addr;
  swd_row_t    cur, h;
  int          n_mismatch, check_count;
  swd_entry_model i_src (.fields({cur.fmt, cur.ps, cur.tg, cur.sh, cur.orr, cur.ir}), .cfg(cur.cfg), .entry_word,
    .entry_config_field);
  swd_decoder i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .entry_valid, .entry_config_field, .entry_word, .size_level_consistent(cur.cons), .addr_check_valid,
    .walk_out_addr, .eff_inner_cache, .eff_outer_cache, .eff_share, .eff_granule, .eff_out_size_enc,
    .eff_out_size_bits, .walk_64bit_format, .hw_table_flag_update, .entry_illegal, .addr_size_fault);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one apb transfer; read data and error land in q and e
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (!pready && n < 16);
    // access-phase values, taken before the completing edge moves any register
    {e, q} = {pslverr, prdata};
    @(posedge pclk);
    {psel, penable} <= 2'b00;
    if (!pready) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  // present an entry at a rising edge, look at it mid-cycle
  task automatic put(input swd_row_t r);
    @(posedge pclk);
    cur <= r;
    @(negedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, entry_valid, addr_check_valid, paddr, pwdata, walk_out_addr, cur} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(q, 32'h571);
    apb(1'b0, 12'h00C, 32'h0);
    check({e, q}, 33'h100000000);
    apb(1'b1, 12'h000, 32'h677);
    entry_valid <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i]);
      check(eff_share, rows[i].esh);
      check(eff_granule, rows[i].eg);
      check(eff_out_size_enc, rows[i].eps);
      check(eff_out_size_bits, sz[rows[i].eps]);
      check(entry_illegal, rows[i].ill);
      check(eff_outer_cache, rows[i].orr);
      check(eff_inner_cache, rows[i].ir);
      check(walk_64bit_format, rows[i].fmt);
      check(hw_table_flag_update, rows[i].ir[0] & rows[i].orr[0]);
    end
    apb(1'b0, 12'h004, 32'h0);
    check(q, 32'h7987);
    // earlier revision: 52-bit and reserved sizes fall back to 48
    apb(1'b1, 12'h000, 32'h675);
    for (int p = 6; p < 8; p++) begin
      h = rows[0];
      h.ps = p[2:0];
      put(h);
      check(eff_out_size_bits, 6'h30);
    end
    // 64KB not advertised as supported
    apb(1'b1, 12'h000, 32'h637);
    h.tg = 2'h1;
    put(h);
    check(entry_illegal, 1'b1);
    // 40-bit output size: bit 40 faults, bit 39 does not
    apb(1'b1, 12'h000, 32'h677);
    h.tg = 2'h0;
    h.ps = 3'h2;
    put(h);
    @(posedge pclk);
    {addr_check_valid, walk_out_addr} <= {1'b1, 52'h1 << 40};
    @(negedge pclk);
    check(addr_size_fault, 1'b1);
    @(posedge pclk);
    walk_out_addr <= 52'h1 << 39;
    @(negedge pclk);
    check(addr_size_fault, 1'b0);
    // 52-bit size with a 4KB granule: bit 50 stays inside the limit
    h.ps = 3'h6;
    put(h);
    @(posedge pclk);
    walk_out_addr <= 52'h1 << 50;
    @(negedge pclk);
    check(addr_size_fault, 1'b0);
    @(posedge pclk);
    addr_check_valid <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    check(q, 32'h1);
    // no second stage present: fields read as zero
    apb(1'b1, 12'h000, 32'h676);
    put(rows[1]);
    check({eff_inner_cache, eff_share, entry_illegal}, 5'h04);
    finish_test();
  end
endmodule
`default_nettype wire
